// file: design/ppa_regs.vh
`ifndef PPA_REGS_VH
`define PPA_REGS_VH
// system clock rate in khz
`define PPA_CLK_KHZ          25000
// power-on reset interval in microseconds
`define PPA_POR_US           1000
`define PPA_POR_CYC          ((`PPA_POR_US * `PPA_CLK_KHZ) / 1000)
// conversion length in steps of 64 conversion ticks
`define PPA_CONV_CYC         64
// filter notch divider of the conversion clock
`define PPA_NOTCH_DIV        2560
// internal serial clock half period in system clocks
`define PPA_SCK_HALF         4
// output word layout
`define PPA_WORD_BITS        19
`define PPA_RESULT_BITS      16
`define PPA_BIT_DONE         18
`define PPA_BIT_CHAN         17
`define PPA_BIT_SIGN         16
`endif

// file: design/ppa_core.v
`timescale 1ns/10ps
`default_nettype none
`include "ppa_regs.vh"

// Overview of operation
// [R1] cycle conversion, sleep, data output repeatedly
// [R2] channel 0 first, then alternate channels
// [R3] sleep after conversion while select high
// [R4] result held unchanged while sleeping
// [R5] select low enables output, wakes device
// [R6] select high before first rise: back asleep
// [R7] select low past first rise: shift out
// [R8] select rising during transfer aborts, converts
// [R9] output ends after 19 bits, then convert
// [R10] data changes on falling clock edge
// [R11] extra clock pulses shift out ones
// [R12] output word is the just-finished conversion
// [R13] data pin high impedance while select high
// [R14] status bit shown in conversion and sleep
// [R15] internal mode drives clock, external receives
// [R16] clock mode sampled at reset, select fall
// [R17] no configuration registers, same cycle always
// [R18] oscillator select low: internal clock used
// [R19] external clock scales conversion by 2560
// [R20] calibration hidden inside each conversion
// [R21] power-on reset clears state, channel 0
// [R22] after reset a normal conversion starts
// [R23] word: done, channel, sign, then 16 bits
// [R24] done flag high during conversion, low after
// [R25] clock ignored by shifter while select high
// [R26] host waits for done low before reading
module ppa_core #(
    parameter POR_CYC = `PPA_POR_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        cs_n,
    input  wire        sck_i,
    output reg         sck_o,
    output wire        sck_oe,
    output reg         sdo_o,
    output wire        sdo_oe,
    input  wire        oscillator_select_input,
    input  wire [15:0] conv_data,
    input  wire        result_sign_bit,
    output wire        conv_busy,
    output wire        out_valid,
    input  wire        out_ready,
    output wire [18:0] out_word
);

    localparam [3:0] ST_POR   = 4'h1;
    localparam [3:0] ST_CONV  = 4'h2;
    localparam [3:0] ST_SLEEP = 4'h4;
    localparam [3:0] ST_OUT   = 4'h8;

    reg [3:0]  state_q;
    reg [31:0] por_cnt_q;
    reg [11:0] tick_cnt_q;
    reg [7:0]  conv_cnt_q;
    reg        chan_q;
    reg        chan_done_q;
    reg [18:0] shift_q;
    reg [7:0]  bit_cnt_q;
    reg        started_q;
    reg        ext_mode_q;
    reg        cs_q;
    reg        sck_q;
    reg [2:0]  half_cnt_q;
    reg        osc_q;
    reg [1:0]  buf_cnt_q;
    reg [18:0] buf0_q;
    reg [18:0] buf1_q;

    wire cs_fall  = cs_q & ~cs_n;
    wire cs_rise  = ~cs_q & cs_n;
    // active serial clock level depends on the latched mode
    wire sck_now  = ext_mode_q ? sck_i : sck_o;
    wire sck_rise = ~sck_q & sck_now;
    wire sck_fall = sck_q & ~sck_now;
    wire osc_rise = ~osc_q & oscillator_select_input;
    // the conversion advances on a tick from the chosen clock source
    wire conv_tick;
    wire word_push;

    // [R18] clock source select
    assign conv_tick = oscillator_select_input | osc_q ? osc_rise : 1'b1;

    // [R24] done flag real time
    assign conv_busy = state_q[1] | state_q[0];
    // [R13] high impedance when deselected
    assign sdo_oe    = ~cs_n;
    // [R15] drive clock in internal mode
    assign sck_oe    = ~ext_mode_q & ~cs_n & state_q[3];

    // edge history of pins
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_q  <= 1'b1;
            sck_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            cs_q  <= cs_n;
            sck_q <= sck_now;
            osc_q <= oscillator_select_input;
        end
    end

    // [R16] mode latch after reset and on select fall
    // [R17] pin timing is the only configuration
    // a host holding the clock low asks for external mode; a floating pin
    // rests high on its pull-up, which leaves the block driving the clock
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_mode_q <= 1'b0;
        end else if (state_q[0] || cs_fall) begin
            ext_mode_q <= ~sck_i;
        end
    end

    // internal serial clock generator, runs only in output state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_o      <= 1'b0;
            half_cnt_q <= 3'h0;
        end else if (!state_q[3] || cs_n || ext_mode_q) begin
            sck_o      <= 1'b0;
            half_cnt_q <= 3'h0;
        end else if (half_cnt_q == 3'd`PPA_SCK_HALF - 3'd1) begin
            sck_o      <= ~sck_o;
            half_cnt_q <= 3'h0;
        end else begin
            half_cnt_q <= half_cnt_q + 3'h1;
        end
    end

    // [R1] main state sequence
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_POR;
            por_cnt_q   <= 32'h0;
            tick_cnt_q  <= 12'h0;
            conv_cnt_q  <= 8'h0;
            chan_q      <= 1'b0;
            chan_done_q <= 1'b0;
            shift_q     <= 19'h0;
            bit_cnt_q   <= 8'h0;
            started_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_POR: begin
                    // [R21] hold reset interval
                    if (por_cnt_q >= POR_CYC - 1) begin
                        // [R22] start normal conversion
                        state_q <= ST_CONV;
                    end else begin
                        por_cnt_q <= por_cnt_q + 32'h1;
                    end
                end
                ST_CONV: begin
                    // [R19] notch ticks from system clock, or from oscillator_select_input rises once that pin is high
                    if (conv_tick) begin
                        if (tick_cnt_q == 12'd`PPA_NOTCH_DIV / 12'd40 - 12'd1) begin
                            tick_cnt_q <= 12'h0;
                            conv_cnt_q <= conv_cnt_q + 8'h1;
                        end else begin
                            tick_cnt_q <= tick_cnt_q + 12'h1;
                        end
                    end
                    // [R20] calibration folded into conversion time
                    if (conv_cnt_q == 8'd`PPA_CONV_CYC) begin
                        conv_cnt_q  <= 8'h0;
                        tick_cnt_q  <= 12'h0;
                        // [R23] [R12] load fresh word
                        shift_q     <= {1'b0, chan_q, result_sign_bit, conv_data};
                        chan_done_q <= chan_q;
                        // [R2] alternate channel
                        chan_q      <= ~chan_q;
                        // [R3] enter sleep
                        state_q     <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // [R4] [R5] wake on select low
                    started_q <= 1'b0;
                    bit_cnt_q <= 8'h0;
                    if (!cs_n) begin
                        state_q <= ST_OUT;
                    end
                end
                ST_OUT: begin
                    if (cs_n) begin
                        // [R6] [R8] abort or back to sleep
                        state_q <= started_q ? ST_CONV : ST_SLEEP;
                    end else if (sck_rise) begin
                        // [R7] first rise starts transfer
                        started_q <= 1'b1;
                        bit_cnt_q <= bit_cnt_q + 8'h1;
                    end else if (sck_fall && started_q) begin
                        // [R10] [R11] shift, filling with ones
                        shift_q <= {shift_q[17:0], 1'b1};
                        // [R9] nineteenth bit ends output
                        if (bit_cnt_q >= 8'd`PPA_WORD_BITS) begin
                            state_q <= ST_CONV;
                        end
                    end
                end
                default: begin
                    state_q <= ST_POR;
                end
            endcase
        end
    end

    // [R14] [R25] data pin source
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_o <= 1'b1;
        end else if (state_q[3]) begin
            sdo_o <= shift_q[`PPA_BIT_DONE];
        end else begin
            sdo_o <= conv_busy;
        end
    end

    // two-entry buffer of finished words toward the user side
    assign word_push = state_q[1] & (conv_cnt_q == 8'd`PPA_CONV_CYC) & (buf_cnt_q != 2'd2);
    assign out_valid = buf_cnt_q != 2'd0;
    assign out_word  = buf0_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_cnt_q <= 2'd0;
            buf0_q    <= 19'h0;
            buf1_q    <= 19'h0;
        end else begin
            case ({word_push, out_valid & out_ready})
                2'b10: begin
                    if (buf_cnt_q == 2'd0) begin
                        buf0_q <= {1'b0, chan_q, result_sign_bit, conv_data};
                    end else begin
                        buf1_q <= {1'b0, chan_q, result_sign_bit, conv_data};
                    end
                    buf_cnt_q <= buf_cnt_q + 2'd1;
                end
                2'b01: begin
                    buf0_q    <= buf1_q;
                    buf_cnt_q <= buf_cnt_q - 2'd1;
                end
                2'b11: begin
                    if (buf_cnt_q == 2'd1) begin
                        buf0_q <= {1'b0, chan_q, result_sign_bit, conv_data};
                    end else begin
                        buf0_q <= buf1_q;
                        buf1_q <= {1'b0, chan_q, result_sign_bit, conv_data};
                    end
                end
                default: begin
                    buf_cnt_q <= buf_cnt_q;
                end
            endcase
        end
    end

endmodule // ppa_core
`default_nettype wire

// file: verif/ppa_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ppa_asserts #(
    parameter POR_CYC = 10
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic        sck_oe,
    input wire logic        sdo_oe,
    input wire logic        conv_busy,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [18:0] out_word
);
    logic [15:0] por_q;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since reset, saturating so it never wraps back under the limit
    always_ff @(posedge clk or posedge rst)
        if (rst) por_q <= 16'h0;
        else if (por_q != 16'hffff) por_q <= por_q + 16'h1;
    // pin checks allow one cycle, though both enables follow cs_n without a register
    a_sdo_hiz: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
        else $error("data pin driven while deselected");
    a_sdo_on: assert property (!cs_n && !$past(cs_n) |-> sdo_oe)
        else $error("data pin idle while selected");
    a_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck_oe)
        else $error("clock pin driven while deselected");
    a_por_busy: assert property (por_q < POR_CYC |-> conv_busy)
        else $error("done flag low in power-on reset");
    // result word, buffer and sleep checks
    a_done_low: assert property (out_valid |-> !out_word[18])
        else $error("done bit set in stored word");
    a_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("stored word changed while stalled");
    a_sleep_stay: assert property (cs_n [*4] ##0 !conv_busy |=> !conv_busy)
        else $error("woke while deselected");
    a_busy_push: assert property ($fell(conv_busy) |-> ##[0:2] out_valid)
        else $error("finished word not offered");
endmodule // ppa_asserts
bind ppa_core ppa_asserts #(.POR_CYC(POR_CYC)) u_chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .conv_busy(conv_busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
);
`default_nettype wire

// file: verif/ppa_host.sv
`timescale 1ns/10ps
`default_nettype none
module ppa_host (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sck_pin,
    output var  logic cs_n,
    output var  logic sck
);
    logic [31:0] rx_q;
    // idle deselected with clock low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        rx_q = 32'h0;
    end
    // clock low at select fall; caller waits for done
    task automatic xfer(input int n, input bit keep);
        @(negedge clk) cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            // bit is taken at the rise
            rx_q = {rx_q[30:0], sdo};
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
            repeat (4) @(negedge clk);
        end
        if (!keep) cs_n = 1'b1;
    endtask
    // clock high at select fall: block drives the clock
    task automatic xfer_int(input int n);
        @(negedge clk) sck = 1'b1;
        @(negedge clk) cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge sck_pin);
            rx_q = {rx_q[30:0], sdo};
        end
        @(negedge clk);
        cs_n = 1'b1;
        sck = 1'b0;
    endtask
    task automatic drop;
        cs_n = 1'b1;
    endtask
endmodule // ppa_host
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk, rst, osc_sel, sign, out_ready;
    logic [15:0] data;
    logic [18:0] w [3];
    wire         cs_n, sck_h, sck_o, sck_oe, sdo_o, sdo_oe, busy, out_valid;
    wire  [18:0] out_word;
    int          n_errors = 0;
    int          comparisons = 0;
    // shared pins: device drives the clock only in internal mode
    wire         sck_w = sck_oe ? sck_o : sck_h;
    wire         sdo_w = sdo_oe ? sdo_o : 1'bz;
    ppa_core #(.POR_CYC(10)) DUT (
        .clk(clk), .rst(rst), .cs_n(cs_n), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .oscillator_select_input(osc_sel), .conv_data(data),
        .result_sign_bit(sign), .conv_busy(busy), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word)
    );
    ppa_host host (.clk(clk), .sdo(sdo_w), .sck_pin(sck_w), .cs_n(cs_n), .sck(sck_h));
    // 25 mhz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // the watchdog bounds this wait; two more clocks let the word land
    task automatic wait_conv;
        @(negedge clk iff busy === 1'b0);
        repeat (2) @(negedge clk);
    endtask
    // main sequence: stalled buffer fills with two words, third is dropped
    initial begin
        rst = 1'b1;
        osc_sel = 1'b0;
        out_ready = 1'b0;
        data = 16'h8001;
        sign = 1'b1;
        w[0] = 19'h18001;
        w[1] = 19'h27ffe;
        w[2] = 19'h11234;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        chk(busy, 1);
        host.xfer(0, 1'b1);
        chk(sdo_w, 1);
        host.drop();
        repeat (2) @(negedge clk);
        chk(sdo_oe, 0);
        wait_conv();
        chk(out_word, w[0]);
        host.xfer(0, 1'b0);
        repeat (8) @(negedge clk);
        chk(busy, 0);
        data = 16'h7ffe;
        sign = 1'b0;
        host.xfer(24, 1'b0);
        chk(host.rx_q[23:5], w[0]);
        chk(host.rx_q[4:0], 5'h1f);
        chk(busy, 1);
        wait_conv();
        data = 16'h1234;
        sign = 1'b1;
        host.xfer(4, 1'b0);
        repeat (4) @(negedge clk);
        chk(host.rx_q[3:0], w[1][18:15]);
        chk(busy, 1);
        wait_conv();
        host.xfer(19, 1'b0);
        chk(host.rx_q[18:0], w[2]);
        for (int i = 0; i < 2; i++) begin
            chk(out_word, w[i]);
            out_ready = 1'b1;
            @(negedge clk);
            out_ready = 1'b0;
        end
        chk(out_valid, 0);
        wait_conv();
        host.xfer_int(19);
        chk(host.rx_q[18:0], 19'h31234);
        close_out();
    end
    // watchdog: about seven conversions of about 4100 clocks each
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
